/* File: logic/psr_regs.sv */
`timescale 1ns/1ps
module psr_regs #(
  parameter logic [psr_pkg::SP_W-1:0] SRAM_LAST_ADDR = psr_pkg::SRAM_LAST_DEF, // SRAM top
  parameter bit                       HAS_HIGH_BYTE  = 1'b1                    // High byte built
) (
  input  wire logic                        core_clk,    // Core clock
  input  wire logic                        rst_n,       // Async reset, active low
  input  wire logic                        clk_en,      // Freezes state while low
  // Stack operations
  input  wire logic                        stk_req,     // Stack operation request
  input  wire psr_pkg::psr_stk_op_t        stk_op,      // Push, pop, call, return
  input  wire logic [psr_pkg::SP_W-1:0]    stk_wdata,   // Byte or return address
  output logic                             stk_ready,   // Idle, request taken
  output logic                             stk_done,    // Operation finished
  output logic [psr_pkg::SP_W-1:0]         stk_rdata,   // Popped byte or address
  output logic [psr_pkg::SP_W-1:0]         stack_top_pointer, // Current top of stack
  // Data SRAM
  output logic [psr_pkg::SP_W-1:0]         sram_addr,   // SRAM address
  output logic                             sram_we,     // SRAM write strobe
  output logic                             sram_re,     // SRAM read strobe
  output logic [psr_pkg::BYTE_W-1:0]       sram_wdata,  // SRAM write byte
  input  wire logic [psr_pkg::BYTE_W-1:0]  sram_rdata,  // SRAM read byte
  // I/O register space
  input  wire logic [psr_pkg::IO_AW-1:0]   io_addr,     // I/O offset
  input  wire logic                        io_wr,       // I/O write strobe
  input  wire logic                        io_rd,       // I/O read strobe
  input  wire logic [psr_pkg::BYTE_W-1:0]  io_wdata,    // I/O write byte
  output logic [psr_pkg::BYTE_W-1:0]       io_rdata,    // I/O read byte
  // Pointer accesses
  input  wire logic                        ptr_req,     // Pointer access request
  input  wire logic [1:0]                  ptr_sel,     // X, Y or Z pair
  input  wire psr_pkg::psr_ptr_mode_t      ptr_mode,    // Addressing use
  input  wire logic [psr_pkg::DISP_W-1:0]  ptr_disp,    // Displacement
  output logic [psr_pkg::SP_W-1:0]         ptr_addr,    // Effective address
  output logic                             ptr_addr_valid, // Address strobe
  // Upper six work registers
  input  wire logic                        rf_we,       // Work register write
  input  wire logic [psr_pkg::IDX_W-1:0]   rf_idx,      // Write index 0..5
  input  wire logic [psr_pkg::BYTE_W-1:0]  rf_wdata,    // Write byte
  input  wire logic [psr_pkg::IDX_W-1:0]   rf_rd_idx,   // Read index 0..5
  output logic [psr_pkg::BYTE_W-1:0]       rf_rdata     // Read byte
);
  import psr_pkg::*;

  // ==========================================================================
  // Pointer pairs
  psr_ptr_if pif ();

  assign pif.req       = ptr_req;
  assign pif.sel       = ptr_sel;
  assign pif.mode      = ptr_mode;
  assign pif.disp      = ptr_disp;
  assign pif.rf_we     = rf_we;
  assign pif.rf_idx    = rf_idx;
  assign pif.rf_wdata  = rf_wdata;
  assign pif.rf_rd_idx = rf_rd_idx;
  assign ptr_addr       = pif.addr;
  assign ptr_addr_valid = pif.addr_valid;
  assign rf_rdata       = pif.rf_rdata;

  psr_ptr_unit u_ptr (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .pif      (pif.unit)
  );

  // ==========================================================================
  // Stack sequencer
  localparam logic [SP_W-1:0] SP_RST = HAS_HIGH_BYTE ? SRAM_LAST_ADDR
                                     : {BYTE_ZERO, SRAM_LAST_ADDR[BYTE_W-1:0]};

  psr_stk_state_t    state_ff;
  psr_stk_state_t    nxt_state;
  psr_stk_op_t       op_ff;
  psr_stk_op_t       nxt_op;
  logic [SP_W-1:0]   sp_ff;
  logic [SP_W-1:0]   nxt_sp;
  logic [SP_W-1:0]   sp_kept;
  logic [SP_W-1:0]   sp_start_ff;
  logic [BYTE_W-1:0] hold_hi_ff;
  logic              second_ff;
  logic              nxt_second;
  logic [SP_W-1:0]   sram_addr_ff;
  logic [SP_W-1:0]   nxt_sram_addr;
  logic              sram_we_ff;
  logic              nxt_sram_we;
  logic              sram_re_ff;
  logic              nxt_sram_re;
  logic [BYTE_W-1:0] sram_wdata_ff;
  logic [BYTE_W-1:0] nxt_sram_wdata;
  logic              done_ff;
  logic              nxt_done;
  logic [SP_W-1:0]   rdata_ff;
  logic [SP_W-1:0]   nxt_rdata;
  logic [BYTE_W-1:0] io_rdata_ff;
  logic              take;

  assign take = clk_en && stk_req && (state_ff == STK_IDLE);

  always_comb begin
    nxt_state      = state_ff;
    nxt_op         = op_ff;
    nxt_sp         = sp_ff;
    nxt_second     = second_ff;
    nxt_sram_addr  = sram_addr_ff;
    nxt_sram_we    = 1'b0;
    nxt_sram_re    = 1'b0;
    nxt_sram_wdata = sram_wdata_ff;
    nxt_done       = 1'b0;
    nxt_rdata      = rdata_ff;
    case (state_ff)
      STK_IDLE: begin
        if (stk_req) begin
          nxt_op     = stk_op;
          nxt_second = 1'b0;
          if (stk_op == STK_PUSH || stk_op == STK_CALL) begin
            nxt_sram_we    = 1'b1;
            nxt_sram_addr  = sp_ff;
            nxt_sram_wdata = stk_wdata[BYTE_W-1:0];
            nxt_sp         = psr_sub16(sp_ff, STEP_ONE);
            if (stk_op == STK_CALL) begin
              nxt_state = STK_PUSH_HI;
            end else begin
              nxt_done = 1'b1;
            end
          end else begin
            nxt_sp        = psr_add16(sp_ff, STEP_ONE);
            nxt_sram_re   = 1'b1;
            nxt_sram_addr = nxt_sp;
            nxt_state     = STK_POP_WAIT;
          end
        end else if (io_wr && io_addr == IO_SP_LOW) begin
          nxt_sp = {sp_ff[SP_W-1:BYTE_W], io_wdata};
        end else if (io_wr && io_addr == IO_SP_HIGH) begin
          nxt_sp = {io_wdata, sp_ff[BYTE_W-1:0]};
        end
      end
      STK_PUSH_HI: begin
        nxt_sram_we    = 1'b1;
        nxt_sram_addr  = sp_ff;
        nxt_sram_wdata = hold_hi_ff;
        nxt_sp         = psr_sub16(sp_ff, STEP_ONE);
        nxt_done       = 1'b1;
        nxt_state      = STK_IDLE;
      end
      STK_POP_WAIT: begin
        nxt_state = STK_POP_CAP;
      end
      STK_POP_CAP: begin
        if (op_ff == STK_RET && !second_ff) begin
          // High byte sits on top, low byte follows
          nxt_rdata[SP_W-1:BYTE_W] = sram_rdata;
          nxt_second    = 1'b1;
          nxt_sp        = psr_add16(sp_ff, STEP_ONE);
          nxt_sram_re   = 1'b1;
          nxt_sram_addr = nxt_sp;
          nxt_state     = STK_POP_WAIT;
        end else if (op_ff == STK_RET) begin
          nxt_rdata[BYTE_W-1:0] = sram_rdata;
          nxt_done  = 1'b1;
          nxt_state = STK_IDLE;
        end else begin
          nxt_rdata = {BYTE_ZERO, sram_rdata};
          nxt_done  = 1'b1;
          nxt_state = STK_IDLE;
        end
      end
      default: begin
        nxt_state = STK_IDLE;
      end
    endcase
  end

  // Without a high byte the upper bits never leave zero
  assign sp_kept = HAS_HIGH_BYTE ? nxt_sp : {BYTE_ZERO, nxt_sp[BYTE_W-1:0]};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_ff <= SP_RST;
    end else if (clk_en) begin
      sp_ff <= sp_kept;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= STK_IDLE;
      op_ff       <= STK_PUSH;
      second_ff   <= 1'b0;
      hold_hi_ff  <= BYTE_ZERO;
      sp_start_ff <= '0;
    end else if (clk_en) begin
      state_ff  <= nxt_state;
      op_ff     <= nxt_op;
      second_ff <= nxt_second;
      if (take) begin
        hold_hi_ff  <= stk_wdata[SP_W-1:BYTE_W];
        sp_start_ff <= sp_ff;
      end
    end
  end

  // ==========================================================================
  // SRAM strobes and answers; SRAM is expected to share clk_en
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sram_addr_ff  <= '0;
      sram_we_ff    <= 1'b0;
      sram_re_ff    <= 1'b0;
      sram_wdata_ff <= BYTE_ZERO;
    end else if (clk_en) begin
      sram_addr_ff  <= nxt_sram_addr;
      sram_we_ff    <= nxt_sram_we;
      sram_re_ff    <= nxt_sram_re;
      sram_wdata_ff <= nxt_sram_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff  <= 1'b0;
      rdata_ff <= '0;
    end else if (clk_en) begin
      done_ff  <= nxt_done;
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================================
  // I/O read-back
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata_ff <= BYTE_ZERO;
    end else if (clk_en && io_rd) begin
      if (io_addr == IO_SP_LOW) begin
        io_rdata_ff <= sp_ff[BYTE_W-1:0];
      end else if (io_addr == IO_SP_HIGH && HAS_HIGH_BYTE) begin
        io_rdata_ff <= sp_ff[SP_W-1:BYTE_W];
      end else begin
        io_rdata_ff <= BYTE_ZERO;
      end
    end
  end

  assign stk_ready         = (state_ff == STK_IDLE);
  assign stk_done          = done_ff;
  assign stk_rdata         = rdata_ff;
  assign stack_top_pointer = sp_ff;
  assign sram_addr         = sram_addr_ff;
  assign sram_we           = sram_we_ff;
  assign sram_re           = sram_re_ff;
  assign sram_wdata        = sram_wdata_ff;
  assign io_rdata          = io_rdata_ff;

  // ==========================================================================
  // Checks
  logic [BYTE_W-1:0] stk_lo;
  assign stk_lo = stk_wdata[BYTE_W-1:0];

  sequence s_call_taken;
    take && stk_op == STK_CALL;
  endsequence

  sequence s_low_written;
    sram_we && sram_wdata == $past(stk_lo) && sram_addr == $past(sp_ff);
  endsequence

  a_call_low_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_call_taken |=> s_low_written)
    else $error("call did not store low byte at top of stack");

  a_push_one_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
    (done_ff && op_ff == STK_PUSH) |-> sp_ff == psr_sub16(sp_start_ff, STEP_ONE))
    else $error("push moved stack pointer by other than one");

  a_call_two_bytes: assert property (@(posedge core_clk) disable iff (!rst_n)
    (done_ff && op_ff == STK_CALL) |-> sp_ff == psr_sub16(sp_start_ff, STEP_TWO))
    else $error("call moved stack pointer by other than two");

  a_pop_one_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
    (done_ff && op_ff == STK_POP) |-> sp_ff == psr_add16(sp_start_ff, STEP_ONE))
    else $error("pop moved stack pointer by other than one");

  a_ret_two_bytes: assert property (@(posedge core_clk) disable iff (!rst_n)
    (done_ff && op_ff == STK_RET) |-> sp_ff == psr_add16(sp_start_ff, STEP_TWO))
    else $error("return moved stack pointer by other than two");

  a_push_write_top: assert property (@(posedge core_clk) disable iff (!rst_n)
    sram_we |-> sram_addr == psr_add16(sp_ff, STEP_ONE))
    else $error("write not at pointer before decrement");

  a_pop_read_up: assert property (@(posedge core_clk) disable iff (!rst_n)
    sram_re |-> (sram_addr == sp_ff) && !sram_we)
    else $error("read not at pointer after increment");

  a_reset_top: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> sp_ff == SP_RST)
    else $error("stack pointer not at SRAM top after reset");

  a_io_low_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && stk_ready && !stk_req && io_wr && io_addr == IO_SP_LOW)
      |=> sp_ff[BYTE_W-1:0] == $past(io_wdata))
    else $error("low byte write not applied");

  a_high_absent: assert property (@(posedge core_clk) disable iff (!rst_n)
    !HAS_HIGH_BYTE |-> sp_ff[SP_W-1:BYTE_W] == BYTE_ZERO)
    else $error("absent high byte holds nonzero bits");

endmodule

/* File: logic/psr_pkg.sv */
package psr_pkg;

  // ==========================================================================
  // Widths
  localparam int SP_W     = 16;
  localparam int BYTE_W   = 8;
  localparam int IO_AW    = 6;
  localparam int DISP_W   = 6;
  localparam int IDX_W    = 3;
  localparam int NUM_WORK = 6;

  // ==========================================================================
  // I/O register offsets
  localparam logic [IO_AW-1:0] IO_SP_LOW  = 6'h3d;
  localparam logic [IO_AW-1:0] IO_SP_HIGH = 6'h3e;

  // ==========================================================================
  // Reset values and steps
  localparam logic [SP_W-1:0]   SRAM_LAST_DEF = 16'h07ff;
  localparam logic [SP_W-1:0]   STEP_ONE      = 16'h0001;
  localparam logic [SP_W-1:0]   STEP_TWO      = 16'h0002;
  localparam logic [BYTE_W-1:0] BYTE_ZERO     = 8'h00;
  localparam logic [BYTE_W-1:0] WORK_RST      = 8'h00;

  // ==========================================================================
  // Pointer selection, work register index
  localparam logic [1:0]       PTR_X         = 2'h0;
  localparam logic [1:0]       PTR_Y         = 2'h1;
  localparam logic [1:0]       PTR_Z         = 2'h2;
  localparam logic [IDX_W-1:0] WORK_IDX_LAST = 3'h5;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PTR_PLAIN,
    PTR_DISP,
    PTR_POSTINC,
    PTR_PREDEC
  } psr_ptr_mode_t;

  typedef enum logic [1:0] {
    STK_PUSH,
    STK_POP,
    STK_CALL,
    STK_RET
  } psr_stk_op_t;

  typedef enum logic [1:0] {
    STK_IDLE,
    STK_PUSH_HI,
    STK_POP_WAIT,
    STK_POP_CAP
  } psr_stk_state_t;

  // ==========================================================================
  // Address arithmetic, wraps at 16 bits
  function automatic logic [SP_W-1:0] psr_add16(input logic [SP_W-1:0] a,
                                                input logic [SP_W-1:0] b);
    psr_add16 = a + b;
  endfunction

  function automatic logic [SP_W-1:0] psr_sub16(input logic [SP_W-1:0] a,
                                                input logic [SP_W-1:0] b);
    psr_sub16 = a - b;
  endfunction

endpackage

/* File: logic/psr_ptr_if.sv */
`timescale 1ns/1ps
interface psr_ptr_if;
  import psr_pkg::*;

  logic                 req;
  logic [1:0]           sel;
  psr_ptr_mode_t        mode;
  logic [DISP_W-1:0]    disp;
  logic [SP_W-1:0]      addr;
  logic                 addr_valid;
  logic                 rf_we;
  logic [IDX_W-1:0]     rf_idx;
  logic [BYTE_W-1:0]    rf_wdata;
  logic [IDX_W-1:0]     rf_rd_idx;
  logic [BYTE_W-1:0]    rf_rdata;

  modport core (output req, sel, mode, disp, rf_we, rf_idx, rf_wdata, rf_rd_idx,
                input  addr, addr_valid, rf_rdata);
  modport unit (input  req, sel, mode, disp, rf_we, rf_idx, rf_wdata, rf_rd_idx,
                output addr, addr_valid, rf_rdata);
endinterface

/* File: logic/psr_ptr_unit.sv */
`timescale 1ns/1ps
module psr_ptr_unit (
  input  wire logic core_clk, // Core clock
  input  wire logic rst_n,    // Async reset, active low
  input  wire logic clk_en,   // Freezes state while low
  psr_ptr_if.unit   pif       // Pointer port from the core
);
  import psr_pkg::*;

  // ==========================================================================
  // Pointer selection and address generation
  logic [BYTE_W-1:0] work_ff [NUM_WORK];
  logic [IDX_W-1:0]  lo_idx;
  logic [IDX_W-1:0]  hi_idx;
  logic              sel_ok;
  logic              ptr_upd;
  logic [SP_W-1:0]   cur_ptr;
  logic [SP_W-1:0]   nxt_ptr;
  logic [SP_W-1:0]   nxt_addr;
  logic [SP_W-1:0]   addr_ff;
  logic              valid_ff;
  logic [BYTE_W-1:0] rdata_ff;

  assign sel_ok = (pif.sel <= PTR_Z);
  assign lo_idx = {pif.sel, 1'b0};
  assign hi_idx = {pif.sel, 1'b1};

  always_comb begin
    cur_ptr  = sel_ok ? {work_ff[hi_idx], work_ff[lo_idx]} : '0;
    nxt_ptr  = cur_ptr;
    nxt_addr = cur_ptr;
    ptr_upd  = 1'b0;
    case (pif.mode)
      PTR_PLAIN: begin
        nxt_addr = cur_ptr;
      end
      PTR_DISP: begin
        nxt_addr = psr_add16(cur_ptr, {{(SP_W-DISP_W){1'b0}}, pif.disp});
      end
      PTR_POSTINC: begin
        nxt_ptr = psr_add16(cur_ptr, STEP_ONE);
        ptr_upd = 1'b1;
      end
      PTR_PREDEC: begin
        nxt_ptr  = psr_sub16(cur_ptr, STEP_ONE);
        nxt_addr = nxt_ptr;
        ptr_upd  = 1'b1;
      end
      default: begin
        nxt_addr = cur_ptr;
      end
    endcase
  end

  // ==========================================================================
  // Work registers; a pointer step wins over a plain write in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_WORK; i++) begin
        work_ff[i] <= WORK_RST;
      end
    end else if (clk_en) begin
      if (pif.req && sel_ok && ptr_upd) begin
        work_ff[lo_idx] <= nxt_ptr[BYTE_W-1:0];
        work_ff[hi_idx] <= nxt_ptr[SP_W-1:BYTE_W];
      end else if (pif.rf_we && (pif.rf_idx <= WORK_IDX_LAST)) begin
        work_ff[pif.rf_idx] <= pif.rf_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff  <= '0;
      valid_ff <= 1'b0;
      rdata_ff <= WORK_RST;
    end else if (clk_en) begin
      valid_ff <= pif.req && sel_ok;
      if (pif.req && sel_ok) begin
        addr_ff <= nxt_addr;
      end
      rdata_ff <= (pif.rf_rd_idx <= WORK_IDX_LAST) ? work_ff[pif.rf_rd_idx] : BYTE_ZERO;
    end
  end

  assign pif.addr       = addr_ff;
  assign pif.addr_valid = valid_ff;
  assign pif.rf_rdata   = rdata_ff;

  // ==========================================================================
  // Checks
  logic step_take;
  assign step_take = clk_en && pif.req && sel_ok;

  a_ptr_post_inc: assert property (@(posedge core_clk) disable iff (!rst_n)
    (step_take && pif.mode == PTR_POSTINC) |=>
      pif.addr_valid && (pif.addr == $past(cur_ptr))
      && ({work_ff[$past(hi_idx)], work_ff[$past(lo_idx)]}
          == psr_add16($past(cur_ptr), STEP_ONE)))
    else $error("post-increment pointer step wrong");

  a_ptr_pre_dec: assert property (@(posedge core_clk) disable iff (!rst_n)
    (step_take && pif.mode == PTR_PREDEC) |=>
      (pif.addr == psr_sub16($past(cur_ptr), STEP_ONE))
      && ({work_ff[$past(hi_idx)], work_ff[$past(lo_idx)]} == pif.addr))
    else $error("pre-decrement pointer step wrong");

  a_ptr_disp_add: assert property (@(posedge core_clk) disable iff (!rst_n)
    (step_take && pif.mode == PTR_DISP && !pif.rf_we) |=>
      (pif.addr == psr_add16($past(cur_ptr), {{(SP_W-DISP_W){1'b0}}, $past(pif.disp)}))
      && ({work_ff[$past(hi_idx)], work_ff[$past(lo_idx)]} == $past(cur_ptr)))
    else $error("displacement access wrong or pointer moved");

endmodule

/* File: tb/psr_sram_model.sv */
`timescale 1ns/1ps
// ====================
// Data SRAM with one cycle of read latency
module psr_sram_model (
  input  wire logic        core_clk,   // Core clock
  input  wire logic        clk_en,     // Shared with the block
  input  wire logic [15:0] sram_addr,  // Address
  input  wire logic        sram_we,    // Write strobe
  input  wire logic        sram_re,    // Read strobe
  input  wire logic [7:0]  sram_wdata, // Write byte
  output logic      [7:0]  sram_rdata  // Read byte
);
  logic [7:0] mem [0:65535];
  initial sram_rdata = 8'h5a;
  always @(posedge core_clk) begin
    if (clk_en && sram_we) begin
      mem[sram_addr] <= sram_wdata;
    end
    // Bus not held outside a read, so a late capture sees junk
    if (clk_en) begin
      sram_rdata <= sram_re ? mem[sram_addr] : ~sram_rdata;
    end
  end
endmodule

/* File: tb/psr_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module psr_regs_tb;
  import psr_pkg::*;
  logic          core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, stk_req = 1'b0;
  logic          io_wr = 1'b0, io_rd = 1'b0, ptr_req = 1'b0, rf_we = 1'b0;
  logic          stk_ready, stk_done, sram_we, sram_re, ptr_addr_valid;
  psr_stk_op_t   stk_op = STK_PUSH;
  psr_ptr_mode_t ptr_mode = PTR_PLAIN;
  logic [15:0]   stk_wdata = 16'h0000, stk_rdata, stack_top_pointer, sram_addr, ptr_addr;
  logic [7:0]    io_wdata = 8'h00, rf_wdata = 8'h00, sram_wdata, sram_rdata, io_rdata;
  logic [7:0]    rf_rdata, rd;
  logic [15:0]   sm_sp;
  logic [7:0]    sm_io_rdata;
  logic [5:0]    io_addr = 6'h00, ptr_disp = 6'h00;
  logic [2:0]    rf_idx = 3'h0, rf_rd_idx = 3'h0;
  logic [1:0]    ptr_sel = 2'h0;
  int            fails = 0, num_checks = 0;

  always #5 core_clk = ~core_clk;

  psr_regs #(.SRAM_LAST_ADDR(SRAM_LAST_DEF), .HAS_HIGH_BYTE(1'b1)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .stk_req(stk_req),
    .stk_op(stk_op), .stk_wdata(stk_wdata), .stk_ready(stk_ready), .stk_done(stk_done),
    .stk_rdata(stk_rdata), .stack_top_pointer(stack_top_pointer), .sram_addr(sram_addr),
    .sram_we(sram_we), .sram_re(sram_re), .sram_wdata(sram_wdata),
    .sram_rdata(sram_rdata), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .ptr_req(ptr_req), .ptr_sel(ptr_sel),
    .ptr_mode(ptr_mode), .ptr_disp(ptr_disp), .ptr_addr(ptr_addr),
    .ptr_addr_valid(ptr_addr_valid), .rf_we(rf_we), .rf_idx(rf_idx),
    .rf_wdata(rf_wdata), .rf_rd_idx(rf_rd_idx), .rf_rdata(rf_rdata));

  psr_sram_model sram_u (.core_clk(core_clk), .clk_en(clk_en), .sram_addr(sram_addr),
    .sram_we(sram_we), .sram_re(sram_re), .sram_wdata(sram_wdata),
    .sram_rdata(sram_rdata));

  // Build without the high byte sees only the I/O traffic
  psr_regs #(.SRAM_LAST_ADDR(SRAM_LAST_DEF), .HAS_HIGH_BYTE(1'b0)) dut_small_u (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .stk_req(1'b0),
    .stk_op(stk_op), .stk_wdata(stk_wdata), .stk_ready(), .stk_done(), .stk_rdata(),
    .stack_top_pointer(sm_sp), .sram_addr(), .sram_we(), .sram_re(), .sram_wdata(),
    .sram_rdata(sram_rdata), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(sm_io_rdata), .ptr_req(1'b0), .ptr_sel(ptr_sel),
    .ptr_mode(ptr_mode), .ptr_disp(ptr_disp), .ptr_addr(), .ptr_addr_valid(),
    .rf_we(1'b0), .rf_idx(rf_idx), .rf_wdata(rf_wdata), .rf_rd_idx(rf_rd_idx),
    .rf_rdata());

  // ====================
  // Bus tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic io_w(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge core_clk);
    io_wr <= 1'b0;
    #1;
  endtask

  task automatic io_r(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge core_clk);
    io_rd <= 1'b0;
    #1 d = io_rdata;
  endtask

  task automatic rf_w(input logic [2:0] i, input logic [7:0] d);
    @(posedge core_clk);
    rf_we <= 1'b1;
    rf_idx <= i;
    rf_wdata <= d;
    @(posedge core_clk);
    rf_we <= 1'b0;
  endtask

  task automatic rf_r(input logic [2:0] i, output logic [7:0] d);
    @(posedge core_clk);
    rf_rd_idx <= i;
    @(posedge core_clk);
    #1 d = rf_rdata;
  endtask

  // Request held until the take edge, then bounded wait for done
  task automatic stk(input psr_stk_op_t op, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    stk_req <= 1'b1;
    stk_op <= op;
    stk_wdata <= wd;
    @(posedge core_clk);
    stk_req <= 1'b0;
    #1;
    `CHK("stk ready", op == STK_PUSH, stk_ready)
    `CHK("stk read", op == STK_POP || op == STK_RET, sram_re)
    do begin
      #1;
      n++;
      if (stk_done !== 1'b1) begin
        @(posedge core_clk);
      end
    end while (stk_done !== 1'b1 && n < 10);
    if (stk_done !== 1'b1) begin
      fails++;
      conclude();
    end
  endtask

  task automatic ptr_chk(input logic [1:0] s, input psr_ptr_mode_t m,
                         input logic [15:0] ea, input logic [15:0] pair);
    logic [7:0] lo, hi;
    @(posedge core_clk);
    ptr_req <= 1'b1;
    ptr_sel <= s;
    ptr_mode <= m;
    ptr_disp <= 6'h3f;
    @(posedge core_clk);
    ptr_req <= 1'b0;
    #1;
    `CHK("ptr valid", 1'b1, ptr_addr_valid)
    `CHK("ptr addr", ea, ptr_addr)
    rf_r({s, 1'b0}, lo);
    rf_r({s, 1'b1}, hi);
    `CHK("ptr pair", pair, {hi, lo})
  endtask

  // ====================
  // Scenarios
  task automatic t_reset();
    `CHK("sp reset", SRAM_LAST_DEF, stack_top_pointer)
    `CHK("small sp reset", {8'h00, SRAM_LAST_DEF[7:0]}, sm_sp)
    `CHK("ready", 1'b1, stk_ready)
    io_r(IO_SP_LOW, rd);
    `CHK("sp low rd", SRAM_LAST_DEF[7:0], rd)
    io_r(IO_SP_HIGH, rd);
    `CHK("sp high rd", SRAM_LAST_DEF[15:8], rd)
    `CHK("small high rd", 8'h00, sm_io_rdata)
    io_r(6'h00, rd);
    `CHK("unmapped rd", 8'h00, rd)
  endtask

  // Pointer set at a byte boundary so push borrows from the high byte
  task automatic t_stack();
    io_w(IO_SP_LOW, 8'h00);
    io_w(IO_SP_HIGH, 8'h01);
    io_w(6'h10, 8'h55);
    `CHK("sp set", 16'h0100, stack_top_pointer)
    `CHK("small sp set", 16'h0000, sm_sp)
    stk(STK_PUSH, 16'h00a5);
    `CHK("push we", 1'b1, sram_we)
    `CHK("push addr", 16'h0100, sram_addr)
    `CHK("push sp", 16'h00ff, stack_top_pointer)
    io_r(IO_SP_HIGH, rd);
    `CHK("sp high", 8'h00, rd)
    stk(STK_CALL, 16'h1234);
    `CHK("call sp", 16'h00fd, stack_top_pointer)
    stk(STK_RET, 16'h0000);
    `CHK("ret addr", 16'h1234, stk_rdata)
    `CHK("ret sp", 16'h00ff, stack_top_pointer)
    `CHK("call lo", 8'h34, sram_u.mem[16'h00ff])
    `CHK("call hi", 8'h12, sram_u.mem[16'h00fe])
    stk(STK_POP, 16'h0000);
    `CHK("pop data", 16'h00a5, stk_rdata)
    `CHK("pop sp", 16'h0100, stack_top_pointer)
  endtask

  task automatic t_ptr();
    logic [15:0] p;
    for (int s = 0; s < 3; s++) begin
      p = {8'(s + 1), 8'hff};
      rf_w(3'(2 * s), p[7:0]);
      rf_w(3'(2 * s + 1), p[15:8]);
      ptr_chk(2'(s), PTR_PLAIN, p, p);
      ptr_chk(2'(s), PTR_DISP, p + 16'h003f, p);
      ptr_chk(2'(s), PTR_POSTINC, p, p + 16'h0001);
      ptr_chk(2'(s), PTR_PREDEC, p, p);
    end
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_stack();
    t_ptr();
    conclude();
  end
endmodule
